// File: rtl/fci_host.sv
/*
  Host side command sequencer for a byte-wide parallel flash.
  Turns one request into its bus cycle sequence, unlock writes first where the command needs them, and runs each bus cycle.
  Assumes the flash pins are wired straight to the outputs and data_io_in
  carries the pin level; the device is expected to follow its own command set.
*/
module fci_host
  import fci_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        req_valid_in,
  input  fci_req_t         req_in,
  output logic             req_ready_out,
  output logic             done_out,
  output logic [7:0]       rdata_out,
  output logic             bypass_out,
  output logic [16:0]      addr_out,
  input  wire logic [7:0]  data_io_in,
  output logic [7:0]       data_io_out,
  output logic             data_io_oe_n_out,
  output logic             chip_en_n_out,
  output logic             out_en_n_out,
  output logic             wr_en_n_out,
  output logic             id_high_voltage_out
);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCI_S_IDLE  = 2'b00,
    FCI_S_ISSUE = 2'b01,
    FCI_S_WAIT  = 2'b10,
    FCI_S_ABORT = 2'b11
  } fci_state_t;

  fci_state_t     state_reg, state_next;
  fci_req_t       req_reg, req_next;
  logic [2:0]     step_reg, step_next;
  logic           bypass_reg, bypass_next;
  logic           abort_reg, abort_next;
  logic [7:0]     wait_reg, wait_next;
  logic           hv_reg, hv_next;
  logic           done_reg, done_next;
  logic [7:0]     rd_reg, rd_next;

  logic           bc_start;
  logic           bc_done;
  logic [7:0]     bc_rdata;
  fci_cycle_t     cyc;
  logic [2:0]     last_step;

  // Bus cycle list for a request; step is the index within the sequence
  always_comb begin
    cyc       = '{addr: FCI_ADDR_ANY, data: 8'h00, is_read: 1'b0};
    last_step = 3'h0;
    case (req_reg.op)
      FCI_OP_READ, FCI_OP_READ_ID: begin
        cyc = '{addr: req_reg.addr, data: 8'h00, is_read: 1'b1};
      end
      FCI_OP_RESET1: cyc.data = FCI_CMD_RESET;
      FCI_OP_SUSPEND: cyc.data = FCI_CMD_SUSPEND;
      FCI_OP_RESUME: cyc.data = FCI_CMD_RESUME;
      FCI_OP_BYP_PROGRAM: begin
        last_step = 3'h1;
        cyc = (step_reg == 3'h0) ? '{addr: FCI_ADDR_ANY, data: FCI_CMD_PROGRAM, is_read: 1'b0}
                                 : '{addr: req_reg.addr, data: req_reg.data, is_read: 1'b0};
      end
      FCI_OP_BYP_EXIT: begin
        last_step = 3'h1;
        cyc.data  = (step_reg == 3'h0) ? FCI_CMD_BYP_EXIT1 : FCI_CMD_BYP_EXIT2;
      end
      default: begin
        // Unlocked commands: 555/AA, 2AA/55, then the command word(s)
        // Upper address bits held at zero; only low bits are decoded anyway
        case (step_reg)
          3'h0, 3'h3: cyc = '{addr: FCI_ADDR_UNLOCK1, data: FCI_DATA_UNLOCK1, is_read: 1'b0};
          3'h1, 3'h4: cyc = '{addr: FCI_ADDR_UNLOCK2, data: FCI_DATA_UNLOCK2, is_read: 1'b0};
          default: cyc.addr = FCI_ADDR_UNLOCK1;
        endcase
        case (req_reg.op)
          FCI_OP_RESET3: begin
            last_step = 3'h2;
            if (step_reg == 3'h2) begin
              cyc = '{addr: FCI_ADDR_ANY, data: FCI_CMD_RESET, is_read: 1'b0};
            end
          end
          FCI_OP_IDENT: begin
            last_step = 3'h2;
            if (step_reg == 3'h2) cyc.data = FCI_CMD_IDENT;
          end
          FCI_OP_BYPASS: begin
            last_step = 3'h2;
            if (step_reg == 3'h2) cyc.data = FCI_CMD_BYPASS;
          end
          FCI_OP_PROGRAM: begin
            last_step = 3'h3;
            if (step_reg == 3'h2) cyc.data = FCI_CMD_PROGRAM;
            if (step_reg == 3'h3) cyc = '{addr: req_reg.addr, data: req_reg.data, is_read: 1'b0};
          end
          FCI_OP_CHIP_ERASE, FCI_OP_BLK_ERASE: begin
            last_step = 3'h5;
            if (step_reg == 3'h2) cyc.data = FCI_CMD_ERASE_PRE;
            if (step_reg == 3'h5) begin
              cyc = (req_reg.op == FCI_OP_CHIP_ERASE)
                  ? '{addr: FCI_ADDR_UNLOCK1, data: FCI_CMD_CHIP_ERASE, is_read: 1'b0}
                  : '{addr: req_reg.addr, data: FCI_CMD_BLK_ERASE, is_read: 1'b0};
            end
          end
          default: ;
        endcase
      end
    endcase
  end

  always_comb begin
    state_next  = state_reg;
    req_next    = req_reg;
    step_next   = step_reg;
    bypass_next = bypass_reg;
    abort_next  = abort_reg;
    wait_next   = wait_reg;
    hv_next     = hv_reg;
    done_next   = 1'b0;
    rd_next     = rd_reg;
    bc_start    = 1'b0;
    case (state_reg)
      FCI_S_IDLE: begin
        if (req_valid_in) begin
          req_next   = req_in;
          step_next  = 3'h0;
          hv_next    = (req_in.op == FCI_OP_READ_ID);
          state_next = FCI_S_ISSUE;
        end
      end
      FCI_S_ISSUE: begin
        bc_start   = 1'b1;
        state_next = FCI_S_WAIT;
      end
      FCI_S_WAIT: begin
        if (bc_done) begin
          if (step_reg == last_step) begin
            rd_next = bc_rdata;
            case (req_reg.op)
              FCI_OP_BYPASS:   bypass_next = 1'b1;
              FCI_OP_BYP_EXIT: bypass_next = 1'b0;
              default: ;   // Reset keeps bypass, as the device does
            endcase
            // Erase or error may be in progress: allow the abort time
            if ((req_reg.op == FCI_OP_RESET1 || req_reg.op == FCI_OP_RESET3) && abort_reg) begin
              wait_next  = 8'(FCI_ABORT_CYC);
              state_next = FCI_S_ABORT;
            end else begin
              done_next  = 1'b1;
              hv_next    = 1'b0;
              state_next = FCI_S_IDLE;
            end
            if (req_reg.op == FCI_OP_PROGRAM || req_reg.op == FCI_OP_BYP_PROGRAM ||
                req_reg.op == FCI_OP_CHIP_ERASE || req_reg.op == FCI_OP_BLK_ERASE) begin
              abort_next = 1'b1;  // Status may hold an error until a reset
            end
          end else begin
            step_next  = step_reg + 3'h1;
            state_next = FCI_S_ISSUE;
          end
        end
      end
      FCI_S_ABORT: begin
        if (wait_reg <= 8'h01) begin
          abort_next = 1'b0;
          done_next  = 1'b1;
          state_next = FCI_S_IDLE;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      default: state_next = FCI_S_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg  <= FCI_S_IDLE;
      req_reg    <= '0;
      step_reg   <= 3'h0;
      bypass_reg <= 1'b0;
      abort_reg  <= 1'b0;
      wait_reg   <= 8'h00;
      hv_reg     <= 1'b0;
      done_reg   <= 1'b0;
      rd_reg     <= 8'h00;
    end else begin
      state_reg  <= state_next;
      req_reg    <= req_next;
      step_reg   <= step_next;
      bypass_reg <= bypass_next;
      abort_reg  <= abort_next;
      wait_reg   <= wait_next;
      hv_reg     <= hv_next;
      done_reg   <= done_next;
      rd_reg     <= rd_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------
  fci_bus_cycle u_cycle (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .start_in      (bc_start),
    .cycle_in      (cyc),
    .data_in       (data_io_in),
    .done_out      (bc_done),
    .rdata_out     (bc_rdata),
    .addr_out      (addr_out),
    .data_out      (data_io_out),
    .data_oe_n_out (data_io_oe_n_out),
    .chip_en_n_out (chip_en_n_out),
    .out_en_n_out  (out_en_n_out),
    .wr_en_n_out   (wr_en_n_out)
  );

  assign req_ready_out       = (state_reg == FCI_S_IDLE);
  assign done_out            = done_reg;
  assign rdata_out           = rd_reg;
  assign bypass_out          = bypass_reg;
  assign id_high_voltage_out = hv_reg;

endmodule // fci_host

// File: rtl/fci_pkg.sv
/*
  Package for the flash command host: command codes, unlock addresses,
  bus timing counts, host opcodes and the request/bus cycle carriers.
  Assumes a 20 MHz clock and a byte-wide flash with 17 address bits.
*/
package fci_pkg;

  localparam int          FCI_CLK_MHZ        = 20;
  localparam int          FCI_ADDR_W         = 17;
  localparam int          FCI_DATA_W         = 8;

  // --------------------------------------------------------------------
  // Bus cycle timing
  // --------------------------------------------------------------------
  localparam int          FCI_SETUP_NS       = 50;
  localparam int          FCI_STROBE_NS      = 100;
  localparam int          FCI_ABORT_US       = 10;
  localparam int          FCI_SETUP_CYC      = (FCI_SETUP_NS * FCI_CLK_MHZ + 999) / 1000;
  localparam int          FCI_STROBE_CYC     = (FCI_STROBE_NS * FCI_CLK_MHZ + 999) / 1000;
  localparam int          FCI_ABORT_CYC      = FCI_ABORT_US * FCI_CLK_MHZ;
  localparam int          FCI_CNT_W          = 8;

  // --------------------------------------------------------------------
  // Command words
  // --------------------------------------------------------------------
  localparam logic [16:0] FCI_ADDR_UNLOCK1   = 17'h00555;
  localparam logic [16:0] FCI_ADDR_UNLOCK2   = 17'h002aa;
  localparam logic [16:0] FCI_ADDR_ANY       = 17'h00000;
  localparam logic [7:0]  FCI_DATA_UNLOCK1   = 8'haa;
  localparam logic [7:0]  FCI_DATA_UNLOCK2   = 8'h55;
  localparam logic [7:0]  FCI_CMD_RESET      = 8'hf0;
  localparam logic [7:0]  FCI_CMD_IDENT      = 8'h90;
  localparam logic [7:0]  FCI_CMD_PROGRAM    = 8'ha0;
  localparam logic [7:0]  FCI_CMD_BYPASS     = 8'h20;
  localparam logic [7:0]  FCI_CMD_BYP_EXIT1  = 8'h90;
  localparam logic [7:0]  FCI_CMD_BYP_EXIT2  = 8'h00;
  localparam logic [7:0]  FCI_CMD_ERASE_PRE  = 8'h80;
  localparam logic [7:0]  FCI_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  FCI_CMD_BLK_ERASE  = 8'h30;
  localparam logic [7:0]  FCI_CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0]  FCI_CMD_RESUME     = 8'h30;

  // Identification read addresses (A1,A0)
  localparam logic [16:0] FCI_ID_MAKER_ADDR  = 17'h00000;
  localparam logic [16:0] FCI_ID_PART_ADDR   = 17'h00001;
  localparam logic [16:0] FCI_ID_PROT_ADDR   = 17'h00002;
  localparam int          FCI_BLK_LSB        = 14;

  // --------------------------------------------------------------------
  // Host operations
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    FCI_OP_READ        = 4'h0,
    FCI_OP_RESET1      = 4'h1,
    FCI_OP_RESET3      = 4'h2,
    FCI_OP_IDENT       = 4'h3,
    FCI_OP_PROGRAM     = 4'h4,
    FCI_OP_BYPASS      = 4'h5,
    FCI_OP_BYP_PROGRAM = 4'h6,
    FCI_OP_BYP_EXIT    = 4'h7,
    FCI_OP_CHIP_ERASE  = 4'h8,
    FCI_OP_BLK_ERASE   = 4'h9,
    FCI_OP_SUSPEND     = 4'ha,
    FCI_OP_RESUME      = 4'hb,
    FCI_OP_READ_ID     = 4'hc
  } fci_op_t;

  typedef struct packed {
    fci_op_t     op;
    logic [16:0] addr;
    logic [7:0]  data;
  } fci_req_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        is_read;
  } fci_cycle_t;

endpackage

// File: rtl/fci_bus_cycle.sv
/*
  One flash bus cycle (write or read) on the enable pins.
  Assumes the caller holds cycle_in stable while start_in is high.
*/
module fci_bus_cycle
  import fci_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  fci_cycle_t       cycle_in,
  input  wire logic [7:0]  data_in,
  output logic             done_out,
  output logic [7:0]       rdata_out,
  output logic [16:0]      addr_out,
  output logic [7:0]       data_out,
  output logic             data_oe_n_out,
  output logic             chip_en_n_out,
  output logic             out_en_n_out,
  output logic             wr_en_n_out
);

  typedef enum logic [1:0] {
    FCI_BC_IDLE   = 2'b00,
    FCI_BC_SETUP  = 2'b01,
    FCI_BC_STROBE = 2'b10,
    FCI_BC_HOLD   = 2'b11
  } fci_bc_state_t;

  fci_bc_state_t  state_reg, state_next;
  logic [7:0]     cnt_reg, cnt_next;
  fci_cycle_t     cyc_reg, cyc_next;
  logic [7:0]     rdata_reg, rdata_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cyc_next   = cyc_reg;
    rdata_next = rdata_reg;
    done_out   = 1'b0;
    case (state_reg)
      FCI_BC_IDLE: begin
        if (start_in) begin
          cyc_next   = cycle_in;
          cnt_next   = 8'(FCI_SETUP_CYC);
          state_next = FCI_BC_SETUP;
        end
      end
      FCI_BC_SETUP: begin
        if (cnt_reg <= 8'h01) begin
          cnt_next   = 8'(FCI_STROBE_CYC);
          state_next = FCI_BC_STROBE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      FCI_BC_STROBE: begin
        if (cnt_reg <= 8'h01) begin
          // Sample read data just before the strobe rises
          if (cyc_reg.is_read) begin
            rdata_next = data_in;
          end
          state_next = FCI_BC_HOLD;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      FCI_BC_HOLD: begin
        done_out   = 1'b1;
        state_next = FCI_BC_IDLE;
      end
      default: state_next = FCI_BC_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= FCI_BC_IDLE;
      cnt_reg   <= 8'h00;
      cyc_reg   <= '0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cyc_reg   <= cyc_next;
      rdata_reg <= rdata_next;
    end
  end

  // Chip enable spans setup and strobe so address is latched on the later fall
  assign chip_en_n_out = !(state_reg == FCI_BC_SETUP || state_reg == FCI_BC_STROBE);
  assign wr_en_n_out   = !(state_reg == FCI_BC_STROBE && !cyc_reg.is_read);
  assign out_en_n_out  = !(state_reg == FCI_BC_STROBE && cyc_reg.is_read);
  // Data driven through setup and strobe of a write, never during a read
  assign data_oe_n_out = !((state_reg == FCI_BC_SETUP || state_reg == FCI_BC_STROBE) && !cyc_reg.is_read);
  assign addr_out      = cyc_reg.addr;
  assign data_out      = cyc_reg.data;
  assign rdata_out     = rdata_reg;

endmodule // fci_bus_cycle

// File: sim/fci_host_assertions.sv
/*
  Checker for the flash command host: pin strobes and request handshake.
  Assumes it is bound to fci_host and sees only that module's ports.
*/
module fci_host_assertions
  import fci_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        req_valid_in,
  input  wire fci_req_t    req_in,
  input  wire logic        req_ready_out,
  input  wire logic        done_out,
  input  wire logic [16:0] addr_out,
  input  wire logic [7:0]  data_io_out,
  input  wire logic        data_io_oe_n_out,
  input  wire logic        chip_en_n_out,
  input  wire logic        out_en_n_out,
  input  wire logic        wr_en_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  wire taken = req_valid_in && req_ready_out;

  sequence s_strobe;
    !wr_en_n_out [*2] ##1 wr_en_n_out;
  endsequence
  sequence s_write(logic [16:0] a, logic [7:0] d);
    !wr_en_n_out && addr_out == a && data_io_out == d;
  endsequence
  sequence s_data(logic [7:0] d);
    !wr_en_n_out && data_io_out == d;
  endsequence

  strobe_excl_a: assert property (!(!wr_en_n_out && !out_en_n_out))
    else $error("write and output strobes low together");
  write_chip_a: assert property (!wr_en_n_out |-> !chip_en_n_out)
    else $error("write strobe without chip enable");
  drive_quiet_a: assert property (!data_io_oe_n_out |-> out_en_n_out)
    else $error("host drives data while flash outputs");
  strobe_len_a: assert property ($fell(wr_en_n_out) |-> s_strobe)
    else $error("write strobe not two cycles");
  latch_stable_a: assert property (!wr_en_n_out && !$past(wr_en_n_out) |-> $stable(addr_out) && $stable(data_io_out))
    else $error("address or data moved during write strobe");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  take_busy_a: assert property (taken |=> !req_ready_out [*3])
    else $error("ready during a running request");
  unlock_first_a: assert property (taken && req_in.op inside {FCI_OP_PROGRAM, FCI_OP_IDENT, FCI_OP_BYPASS, FCI_OP_RESET3,
    FCI_OP_CHIP_ERASE, FCI_OP_BLK_ERASE}
    |-> ##[1:20] s_write(FCI_ADDR_UNLOCK1, FCI_DATA_UNLOCK1))
    else $error("sequence does not open with first unlock write");
  reset_one_a: assert property (taken && req_in.op == FCI_OP_RESET1 |-> ##[1:20] s_data(FCI_CMD_RESET))
    else $error("reset write missing");
  byp_prog_a: assert property (taken && req_in.op == FCI_OP_BYP_PROGRAM |-> ##[1:20] s_data(FCI_CMD_PROGRAM))
    else $error("bypass program opener missing");
  byp_exit_a: assert property (taken && req_in.op == FCI_OP_BYP_EXIT |-> ##[1:20] s_data(FCI_CMD_BYP_EXIT1))
    else $error("bypass exit opener missing");
endmodule // fci_host_assertions

bind fci_host fci_host_assertions u_chk (
  .clock_in(clock_in), .reset_in(reset_in), .req_valid_in(req_valid_in), .req_in(req_in),
  .req_ready_out(req_ready_out), .done_out(done_out), .addr_out(addr_out), .data_io_out(data_io_out),
  .data_io_oe_n_out(data_io_oe_n_out), .chip_en_n_out(chip_en_n_out), .out_en_n_out(out_en_n_out),
  .wr_en_n_out(wr_en_n_out)
);

// File: sim/fci_flash_model.sv
/*
  Behavioural flash device: command decoder, array, block protection,
  identification codes and program timing.
  Assumes the host drives the strobes; data_out is the data wire level.
*/
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3c, // Arbitrary value
  parameter logic [7:0] STATUS     = 8'h4e,
  parameter logic [7:0] PROT_MASK  = 8'h80,
  parameter int         PROG_NS    = 2000,
  parameter int         ERASE_NS   = 4000,
  parameter logic [7:0] JUNK       = 8'h00
)(
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        drv_n_in,
  input  wire logic        hv_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:131071];
  logic        id_mode = 0, byp = 0, err = 0, busy = 0, fail_next = 0;
  logic        wr_sel = 0, blk_ers = 0;
  logic [7:0]  ers_blk = 8'h00;
  int          gen = 0;
  logic [7:0]  rd, last = 8'h00;
  logic [16:0] wa;
  int          st = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;

  function automatic bit ul(logic [10:0] a, logic [7:0] d);
    return wa[10:0] == a && data_in == d;
  endfunction
  task automatic start_prog(logic [16:0] a, logic [7:0] d);
    if (!PROT_MASK[a[16:14]]) begin
      busy = 1'b1;
      fork begin
        #(PROG_NS);
        if (fail_next) err = 1'b1;
        else mem[a] = mem[a] & d;
        fail_next = 1'b0;
        busy = 1'b0;
      end join_none
    end
  endtask
  // A block erase can be cut short by a reset; a chip erase cannot
  task automatic start_erase(logic [7:0] blocks, logic abortable);
    int g;
    gen++;
    g = gen;
    busy = 1'b1;
    blk_ers = abortable;
    ers_blk = blocks & ~PROT_MASK;
    fork begin
      #(ERASE_NS);
      if (g == gen) begin
        foreach (mem[i]) if (ers_blk[i[16:14]]) mem[i] = 8'hff;
        blk_ers = 1'b0;
        busy = 1'b0;
      end
    end join_none
  endtask

  // Chip enable rises with the write strobe, so the select is taken at the strobe's fall
  always @(negedge we_n_in) begin
    wr_sel = !ce_n_in;
    if (!ce_n_in) wa = addr_in;
  end
  always @(posedge we_n_in) if (wr_sel && (!busy || (blk_ers && data_in == FCI_CMD_RESET))) begin
    if (data_in == FCI_CMD_RESET) begin
      if (busy) begin
        foreach (mem[i]) if (ers_blk[i[16:14]]) mem[i] = JUNK;
        gen++;
        blk_ers = 1'b0;
        busy = 1'b0;
      end
      err = 1'b0;
      id_mode = 1'b0;
      st = 0;
    end else begin
      id_mode = 1'b0;
      case (st)
        0: if (byp) st = (data_in == FCI_CMD_PROGRAM) ? 4 : (data_in == FCI_CMD_BYP_EXIT1) ? 5 : 0;
           else st = ul(FCI_ADDR_UNLOCK1[10:0], FCI_DATA_UNLOCK1) ? 1 : 0;
        1: st = ul(FCI_ADDR_UNLOCK2[10:0], FCI_DATA_UNLOCK2) ? 2 : 0;
        2: begin
          st = ul(FCI_ADDR_UNLOCK1[10:0], FCI_CMD_PROGRAM) ? 3 : 0;
          if (ul(FCI_ADDR_UNLOCK1[10:0], FCI_CMD_ERASE_PRE)) st = 6;
          id_mode = ul(FCI_ADDR_UNLOCK1[10:0], FCI_CMD_IDENT);
          byp = ul(FCI_ADDR_UNLOCK1[10:0], FCI_CMD_BYPASS);
        end
        3, 4: begin
          start_prog(wa, data_in);
          st = 0;
        end
        5: begin
          if (data_in == FCI_CMD_BYP_EXIT2) byp = 1'b0;
          st = 0;
        end
        6: st = ul(FCI_ADDR_UNLOCK1[10:0], FCI_DATA_UNLOCK1) ? 7 : 0;
        7: st = ul(FCI_ADDR_UNLOCK2[10:0], FCI_DATA_UNLOCK2) ? 8 : 0;
        8: begin
          if (ul(FCI_ADDR_UNLOCK1[10:0], FCI_CMD_CHIP_ERASE)) start_erase(8'hff, 1'b0);
          else if (data_in == FCI_CMD_BLK_ERASE) start_erase(8'h01 << wa[16:14], 1'b1);
          st = 0;
        end
        default: st = 0;
      endcase
    end
  end

  always @* begin
    if (busy || err) rd = STATUS;
    else if (hv_in || id_mode) begin
      case (addr_in[1:0])
        2'b00: rd = MAKER_CODE;
        2'b01: rd = PART_CODE;
        2'b10: rd = id_mode ? {7'h00, PROT_MASK[addr_in[16:14]]} : mem[addr_in];
        default: rd = 8'h00;
      endcase
    end else rd = mem[addr_in];
  end
  // An undriven wire shows the inverse of its last level so stale data never passes
  always @(posedge oe_n_in) last = rd;
  always @(posedge drv_n_in) last = data_in;
  assign data_out = !drv_n_in ? data_in : (!ce_n_in && !oe_n_in) ? rd : ~last;
endmodule // fci_flash_model

// File: sim/fci_host_bench.sv
/*
  Self-checking bench for fci_host against the behavioural flash model.
  Assumes the package constants and the model's program time set below.
*/
module fci_host_bench
  import fci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       chk;
    logic [7:0] rd;
    logic       byp;
  } fci_note_t;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
  localparam logic [7:0] STAT  = 8'h4e;
  localparam logic [7:0] JUNK  = 8'h00;

  logic        clock_in = 0, reset_in = 1, req_valid_in = 0, byp_exp = 0;
  fci_req_t    req_in = '0;
  logic        req_ready_out, done_out, bypass_out, data_io_oe_n_out, chip_en_n_out, out_en_n_out;
  logic        wr_en_n_out, id_high_voltage_out;
  logic [7:0]  rdata_out, data_io_out, data_io_in;
  logic [16:0] addr_out;
  fci_note_t   notes[$];
  int          num_errors = 0, n_tests = 0, cycles = 0;

  always #25 clock_in = ~clock_in;

  fci_host dut (.clock_in(clock_in), .reset_in(reset_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .done_out(done_out), .rdata_out(rdata_out), .bypass_out(bypass_out),
    .addr_out(addr_out), .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe_n_out(data_io_oe_n_out),
    .chip_en_n_out(chip_en_n_out), .out_en_n_out(out_en_n_out), .wr_en_n_out(wr_en_n_out),
    .id_high_voltage_out(id_high_voltage_out));
  fci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .STATUS(STAT), .PROT_MASK(8'h80), .PROG_NS(2000),
    .ERASE_NS(4000), .JUNK(JUNK)) flash (
    .ce_n_in(chip_en_n_out), .oe_n_in(out_en_n_out), .we_n_in(wr_en_n_out), .drv_n_in(data_io_oe_n_out),
    .hv_in(id_high_voltage_out), .addr_in(addr_out), .data_in(data_io_out), .data_out(data_io_in));

  // ------------------------------------------------------------------
  // Checking and driving
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_bits(string what, logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic op(fci_op_t o, logic [16:0] a, logic [7:0] d, logic chk, logic [7:0] e);
    notes.push_back('{chk, e, byp_exp});
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_in <= '{o, a, d};
    @(negedge clock_in);
    while (req_ready_out !== 1'b1) @(negedge clock_in);
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    @(negedge clock_in);
    while (done_out !== 1'b1) @(negedge clock_in);
  endtask
  task automatic rd(logic [16:0] a, logic [7:0] e);
    op(FCI_OP_READ, a, 8'h00, 1'b1, e);
  endtask
  task automatic wr(fci_op_t o, logic [16:0] a, logic [7:0] d);
    op(o, a, d, 1'b0, 8'h00);
  endtask

  // Results are settled half a cycle after the edge that raised done
  always @(negedge clock_in) if (done_out === 1'b1) begin
    fci_note_t n;
    n = notes.pop_front();
    if (n.chk) cmp_bits("read", rdata_out, n.rd);
    cmp_bits("bypass", {7'h00, bypass_out}, {7'h00, n.byp});
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    logic [16:0] a, b, c;
    logic [7:0]  d, n;
    void'($urandom(32'h7e67));
    a = {3'h1, 14'($urandom)};
    b = {3'h7, 14'($urandom)};
    c = {3'h2, 12'($urandom), 2'b00};
    d = 8'($urandom);
    n = 8'($urandom);
    repeat (8) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(a, 8'hff);
    wr(FCI_OP_PROGRAM, a, d);
    rd(a, STAT);
    repeat (50) @(posedge clock_in);
    rd(a, d);
    wr(FCI_OP_PROGRAM, a, n);
    repeat (50) @(posedge clock_in);
    rd(a, d & n);
    wr(FCI_OP_PROGRAM, b, 8'h00);
    repeat (50) @(posedge clock_in);
    rd(b, 8'hff);
    wr(FCI_OP_IDENT, FCI_ADDR_ANY, 8'h00);
    rd({3'h7, 12'($urandom), 2'b10}, 8'h01);
    rd({3'h0, 12'($urandom), 2'b10}, 8'h00);
    rd({15'($urandom), 2'b00}, MAKER);
    rd({15'($urandom), 2'b01}, PART);
    wr(FCI_OP_RESET1, FCI_ADDR_ANY, FCI_CMD_RESET);
    rd(a, d & n);
    op(FCI_OP_READ_ID, {15'($urandom), 2'b00}, 8'h00, 1'b1, MAKER);
    op(FCI_OP_READ_ID, {15'($urandom), 2'b01}, 8'h00, 1'b1, PART);
    byp_exp = 1'b1;
    wr(FCI_OP_BYPASS, FCI_ADDR_ANY, 8'h00);
    wr(FCI_OP_BYP_PROGRAM, c, d);
    repeat (50) @(posedge clock_in);
    rd(c, d);
    flash.fail_next = 1'b1;
    wr(FCI_OP_BYP_PROGRAM, c ^ 17'h00010, 8'h00);
    repeat (50) @(posedge clock_in);
    rd(c ^ 17'h00010, STAT);
    wr(FCI_OP_RESET1, FCI_ADDR_ANY, FCI_CMD_RESET);
    rd(c ^ 17'h00010, 8'hff);
    byp_exp = 1'b0;
    wr(FCI_OP_BYP_EXIT, FCI_ADDR_ANY, 8'h00);
    wr(FCI_OP_IDENT, FCI_ADDR_ANY, 8'h00);
    wr(FCI_OP_RESET3, FCI_ADDR_ANY, FCI_CMD_RESET);
    rd(c, d);
    wr(FCI_OP_BLK_ERASE, c, 8'h00);
    rd(c, STAT);
    repeat (100) @(posedge clock_in);
    rd(c, 8'hff);
    rd(a, d & n);
    wr(FCI_OP_CHIP_ERASE, FCI_ADDR_ANY, 8'h00);
    repeat (100) @(posedge clock_in);
    rd(a, 8'hff);
    wr(FCI_OP_BLK_ERASE, a, 8'h00);
    wr(FCI_OP_RESET1, FCI_ADDR_ANY, FCI_CMD_RESET);
    rd(a, JUNK);
    wr(FCI_OP_SUSPEND, FCI_ADDR_ANY, 8'h00);
    wr(FCI_OP_RESUME, FCI_ADDR_ANY, 8'h00);
    rd(c, 8'hff);
    summarize();
  end
endmodule // fci_host_bench
